// [rtl/watch_timer_pkg.sv]
package watch_timer_pkg;

  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_WATCH_INTERVAL_RELOAD = 8'he8;
  localparam logic [7:0] IDX_WATCH_MODE_CONTROL = 8'hea;
  localparam logic [7:0] IDX_WATCHDOG_COMPARE = 8'hec;
  localparam logic [7:0] IDX_WATCHDOG_CONTROL = 8'hed;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hee;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hef;
  localparam logic [7:0] IDX_WATCH_COUNT = 8'hf0;
  localparam logic [7:0] IDX_WATCHDOG_COUNT = 8'hf1;

  // values after reset
  localparam logic [6:0] RST_WATCH_RELOAD_VALUE = 7'h7f;
  localparam logic [7:0] RST_WATCH_MODE_CONTROL = 8'h00;
  localparam logic [7:0] RST_WATCHDOG_COMPARE = 8'h7f;
  localparam logic [1:0] RST_IRQ_MASK = 2'h0;

  // watch_interval_reload fields
  localparam int BIT_WATCH_COUNTER_CLEAR = 7;
  localparam int MSB_WATCH_RELOAD_VALUE = 6;

  // watch_mode_control fields
  localparam int BIT_WATCH_RUN_ENABLE = 7;
  localparam int BIT_RELOAD_WRITE_SELECT = 6;
  localparam int LSB_WATCH_INTERVAL_SELECT = 2;
  localparam int LSB_WATCH_SOURCE_SELECT = 0;
  localparam logic [7:0] MODE_CONTROL_USED_MASK = 8'hcf;

  // watchdog control fields
  localparam int BIT_WATCHDOG_COUNTER_CLEAR = 0;
  localparam int BIT_WATCHDOG_ACTION_SELECT = 1;

  // interrupt status and mask fields
  localparam int BIT_IRQ_WATCH = 0;
  localparam int BIT_IRQ_WATCHDOG = 1;

  // widths and counts
  localparam int WATCH_COUNT_WIDTH = 21;
  localparam int WATCHDOG_COUNT_WIDTH = 7;
  localparam int MAIN_PRESCALE_WIDTH = 7;
  localparam logic [6:0] MAIN_PRESCALE_LAST = 7'h7f;
  localparam logic [20:0] WATCH_LAST_DIV_2E11 = 21'h0007ff;
  localparam logic [20:0] WATCH_LAST_DIV_2E13 = 21'h001fff;
  localparam logic [20:0] WATCH_LAST_DIV_2E14 = 21'h003fff;
  localparam int RELOAD_STEP_SHIFT = 14;

  typedef enum logic [1:0] {
    SRC_SUB,
    SRC_MAIN_DIV128,
    SRC_MAIN,
    SRC_MAIN_DIV2
  } watch_source_t;

  typedef enum logic [1:0] {
    INTV_DIV_2E11,
    INTV_DIV_2E13,
    INTV_DIV_2E14,
    INTV_RELOAD
  } watch_interval_t;

endpackage

// [rtl/watchdog_counter.sv]
`timescale 1ns/1ps
module watchdog_counter
  import watch_timer_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // control
  input wire logic stepTick,
  input wire logic clearReq,
  input wire logic [6:0] compareValue,
  // state
  output logic [6:0] count,
  output logic matchPulse
);

  logic [6:0] count_q;
  logic [6:0] count_d;
  logic match_q;
  logic match_d;

  // step on each interval-timer overflow, restart on clear or match
  always_comb begin
    count_d = count_q;
    match_d = 1'b0;
    if (clearReq) begin
      count_d = '0;
    end else if (stepTick) begin
      if (count_q + 7'h01 == compareValue) begin
        match_d = 1'b1;
        count_d = '0;
      end else begin
        count_d = count_q + 7'h01;
      end
    end
  end

  // register the count and the match pulse
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      count_q <= '0;
      match_q <= 1'b0;
    end else begin
      count_q <= count_d;
      match_q <= match_d;
    end
  end

  assign count = count_q;
  assign matchPulse = match_q;

endmodule

// [rtl/watch_timer_with_watchdog.sv]
// Function
// - watch timer is a 21-bit up-counter stepped by the selected watch clock
// - source field picks sub-clock, main/128, main undivided or main/2
// - interval field picks 2^11, 2^13, 2^14 or reload-based period
// - reload mode period is 2^14 watch clocks times reload value plus one
// - clear bit resets the watch counter and drops back to zero itself
// - watch counter runs only while the run enable bit is one
// - reload write select one blocks watchdog compare writes, zero allows them
// - main/128 source halts in STOP; sub-clock source keeps counting
// - a pending watch interrupt with its mask bit set wakes the CPU from STOP
// - counter range reaches sixty-four seconds on a 32.768 kHz sub-clock
// - watchdog is a 7-bit counter stepped by interval timer overflow
// - watchdog flags a request on the step that would bring its count to the compare low bits
// - watchdog match goes to interrupt or CPU reset by action select
// - watchdog clear bit resets the counter and self-clears after a cycle
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
module watch_timer_with_watchdog
  import watch_timer_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // clocking and power inputs
  input wire logic subClkPin,
  input wire logic stopMode,
  input wire logic intervalOverflow,
  // event outputs
  output logic irq,
  output logic wakeReq,
  output logic cpuResetReq
);

  // register index match
  function automatic logic idxHit(input logic [9:0] adr, input logic [7:0] idx);
    idxHit = (adr[9:2] == idx);
  endfunction

  // bus state
  logic ack_q;
  logic ack_d;
  logic [31:0] rdData_q;
  logic [31:0] rdData_d;
  logic busReq;
  logic busAccept;
  logic busWrite;

  // software-visible registers
  logic [6:0] reloadValue_q;
  logic [6:0] reloadValue_d;
  logic watchClear_q;
  logic watchClear_d;
  logic [7:0] modeControl_q;
  logic [7:0] modeControl_d;
  logic [7:0] wdogCompare_q;
  logic [7:0] wdogCompare_d;
  logic wdogClear_q;
  logic wdogClear_d;
  logic wdogAction_q;
  logic wdogAction_d;
  logic [1:0] irqStatus_q;
  logic [1:0] irqStatus_d;
  logic [1:0] irqMask_q;
  logic [1:0] irqMask_d;
  logic cpuReset_q;
  logic cpuReset_d;

  // sub-clock synchroniser and edge detect
  logic subSync1_q;
  logic subSync2_q;
  logic subSync3_q;
  logic subRise;

  // watch clock generation and counting
  logic [6:0] prescale_q;
  logic [6:0] prescale_d;
  logic [20:0] watchCount_q;
  logic [20:0] watchCount_d;
  logic watchEvent_q;
  logic watchEvent_d;
  logic watchTick;
  logic [20:0] watchLast;
  logic [21:0] reloadSpan;
  watch_source_t watchSource;
  watch_interval_t watchInterval;

  // watchdog
  logic [6:0] wdogCount;
  logic wdogMatch;

  // register selects, shared by the read, write and read-clear paths
  logic hitReload;
  logic hitMode;
  logic hitCompare;
  logic hitControl;
  logic hitStatus;
  logic hitMask;
  logic hitWatchCount;
  logic hitWdogCount;

  assign watchSource = watch_source_t'(modeControl_q[LSB_WATCH_SOURCE_SELECT +: 2]);
  assign watchInterval = watch_interval_t'(modeControl_q[LSB_WATCH_INTERVAL_SELECT +: 2]);

  // one index compare per register; the byte lanes below the index are ignored
  assign hitReload = idxHit(adr_i, IDX_WATCH_INTERVAL_RELOAD);
  assign hitMode = idxHit(adr_i, IDX_WATCH_MODE_CONTROL);
  assign hitCompare = idxHit(adr_i, IDX_WATCHDOG_COMPARE);
  assign hitControl = idxHit(adr_i, IDX_WATCHDOG_CONTROL);
  assign hitStatus = idxHit(adr_i, IDX_IRQ_STATUS);
  assign hitMask = idxHit(adr_i, IDX_IRQ_MASK);
  assign hitWatchCount = idxHit(adr_i, IDX_WATCH_COUNT);
  assign hitWdogCount = idxHit(adr_i, IDX_WATCHDOG_COUNT);

  // bus request decode; ack rises one cycle after the request
  assign busReq = cyc_i & stb_i;
  assign busAccept = busReq & ack_q;
  assign busWrite = busAccept & we_i & sel_i[0];
  assign ack_o = ack_q;
  assign dat_o = rdData_q;

  // ack and read data next values
  always_comb begin
    ack_d = busReq & ~ack_q;
    rdData_d = rdData_q;
    if (busReq & ~ack_q) begin
      rdData_d = '0;
      if (hitMode) begin
        rdData_d[7:0] = modeControl_q & MODE_CONTROL_USED_MASK;
      end else if (hitCompare) begin
        rdData_d[7:0] = wdogCompare_q;
      end else if (hitControl) begin
        rdData_d[BIT_WATCHDOG_ACTION_SELECT] = wdogAction_q;
      end else if (hitStatus) begin
        rdData_d[1:0] = irqStatus_q;
      end else if (hitMask) begin
        rdData_d[1:0] = irqMask_q;
      end else if (hitWatchCount) begin
        rdData_d[20:0] = watchCount_q;
      end else if (hitWdogCount) begin
        rdData_d[6:0] = wdogCount;
      end
    end
  end

  // bus registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
      rdData_q <= '0;
    end else begin
      ack_q <= ack_d;
      rdData_q <= rdData_d;
    end
  end

  // register file writes and self-clearing bits
  always_comb begin
    reloadValue_d = reloadValue_q;
    watchClear_d = 1'b0;
    modeControl_d = modeControl_q;
    wdogCompare_d = wdogCompare_q;
    wdogClear_d = 1'b0;
    wdogAction_d = wdogAction_q;
    irqMask_d = irqMask_q;
    if (busWrite) begin
      if (hitReload && modeControl_q[BIT_RELOAD_WRITE_SELECT]) begin
        reloadValue_d = dat_i[MSB_WATCH_RELOAD_VALUE:0];
        watchClear_d = dat_i[BIT_WATCH_COUNTER_CLEAR];
      end
      if (hitMode) begin
        modeControl_d = dat_i[7:0] & MODE_CONTROL_USED_MASK;
      end
      if (hitCompare && !modeControl_q[BIT_RELOAD_WRITE_SELECT]) begin
        wdogCompare_d = dat_i[7:0];
      end
      if (hitControl) begin
        wdogClear_d = dat_i[BIT_WATCHDOG_COUNTER_CLEAR];
        wdogAction_d = dat_i[BIT_WATCHDOG_ACTION_SELECT];
      end
      if (hitMask) begin
        irqMask_d = dat_i[1:0];
      end
    end
  end

  // register file flip-flops
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reloadValue_q <= RST_WATCH_RELOAD_VALUE;
      watchClear_q <= 1'b0;
      modeControl_q <= RST_WATCH_MODE_CONTROL;
      wdogCompare_q <= RST_WATCHDOG_COMPARE;
      wdogClear_q <= 1'b0;
      wdogAction_q <= 1'b0;
      irqMask_q <= RST_IRQ_MASK;
    end else begin
      reloadValue_q <= reloadValue_d;
      watchClear_q <= watchClear_d;
      modeControl_q <= modeControl_d;
      wdogCompare_q <= wdogCompare_d;
      wdogClear_q <= wdogClear_d;
      wdogAction_q <= wdogAction_d;
      irqMask_q <= irqMask_d;
    end
  end

  // sub-clock pin passes two flip-flops; the third only feeds edge detect
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      subSync1_q <= 1'b0;
      subSync2_q <= 1'b0;
      subSync3_q <= 1'b0;
    end else begin
      subSync1_q <= subClkPin;
      subSync2_q <= subSync1_q;
      subSync3_q <= subSync2_q;
    end
  end

  assign subRise = subSync2_q & ~subSync3_q;

  // main clock prescaler; the main clock is gone while in STOP
  always_comb begin
    prescale_d = prescale_q;
    if (!stopMode) begin
      prescale_d = prescale_q + 7'h01;
    end
  end

  // prescaler flip-flops
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prescale_q <= '0;
    end else begin
      prescale_q <= prescale_d;
    end
  end

  // watch clock selection; only the sub-clock keeps ticking in STOP
  always_comb begin
    unique case (watchSource)
      SRC_SUB: watchTick = subRise;
      SRC_MAIN_DIV128: watchTick = ~stopMode & (prescale_q == MAIN_PRESCALE_LAST);
      SRC_MAIN: watchTick = ~stopMode;
      SRC_MAIN_DIV2: watchTick = ~stopMode & prescale_q[0];
    endcase
  end

  // reload period spans 2^14 watch clocks per step; 128 steps fill 21 bits
  assign reloadSpan = {({1'b0, reloadValue_q} + 8'h01), 14'h0000} - 22'h000001;

  // last count value of the selected interval
  always_comb begin
    unique case (watchInterval)
      INTV_DIV_2E11: watchLast = WATCH_LAST_DIV_2E11;
      INTV_DIV_2E13: watchLast = WATCH_LAST_DIV_2E13;
      INTV_DIV_2E14: watchLast = WATCH_LAST_DIV_2E14;
      INTV_RELOAD: watchLast = reloadSpan[20:0];
    endcase
  end

  // watch counter: clear first, then count while enabled
  always_comb begin
    watchCount_d = watchCount_q;
    watchEvent_d = 1'b0;
    if (watchClear_q) begin
      watchCount_d = '0;
    end else if (modeControl_q[BIT_WATCH_RUN_ENABLE] && watchTick) begin
      if (watchCount_q == watchLast) begin
        watchCount_d = '0;
        watchEvent_d = 1'b1;
      end else begin
        watchCount_d = watchCount_q + 21'h000001;
      end
    end
  end

  // watch counter flip-flops
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      watchCount_q <= '0;
      watchEvent_q <= 1'b0;
    end else begin
      watchCount_q <= watchCount_d;
      watchEvent_q <= watchEvent_d;
    end
  end

  // watchdog counter and compare
  watchdog_counter u_watchdog (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .stepTick(intervalOverflow),
    .clearReq(wdogClear_q),
    .compareValue(wdogCompare_q[6:0]),
    .count(wdogCount),
    .matchPulse(wdogMatch)
  );

  // sticky status; a read clears only the bits it returned, a new event wins
  always_comb begin
    irqStatus_d = irqStatus_q;
    cpuReset_d = wdogMatch & wdogAction_q;
    if (busAccept && !we_i && hitStatus) begin
      irqStatus_d = irqStatus_q & ~rdData_q[1:0];
    end
    if (watchEvent_q) begin
      irqStatus_d[BIT_IRQ_WATCH] = 1'b1;
    end
    if (wdogMatch && !wdogAction_q) begin
      irqStatus_d[BIT_IRQ_WATCHDOG] = 1'b1;
    end
  end

  // status and reset request flip-flops
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irqStatus_q <= '0;
      cpuReset_q <= 1'b0;
    end else begin
      irqStatus_q <= irqStatus_d;
      cpuReset_q <= cpuReset_d;
    end
  end

  // interrupt and wake outputs
  assign irq = |(irqStatus_q & irqMask_q);
  assign wakeReq = stopMode & irqStatus_q[BIT_IRQ_WATCH] & irqMask_q[BIT_IRQ_WATCH];
  assign cpuResetReq = cpuReset_q;

endmodule

// [tb/watch_timer_monitor.sv]
`timescale 1ns/1ps
module watch_timer_monitor
  import watch_timer_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // bus handshake
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // power and events
  input wire logic stopMode,
  input wire logic intervalOverflow,
  input wire logic irq,
  input wire logic wakeReq,
  input wire logic cpuResetReq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // a request not yet answered, and a wake pending with no bus answer
  sequence busReq;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence wakeHeld;
    wakeReq && !ack_o ##1 stopMode;
  endsequence
  // bus answer comes one cycle after the request and lasts one cycle
  chk_ack_answer: assert property (busReq |=> ack_o) else $error("ack missing");
  chk_ack_single: assert property (ack_o |=> !ack_o) else $error("ack too long");
  chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
  chk_reset_quiet: assert property ($past(sys_rst) |-> !ack_o && !irq && !cpuResetReq)
    else $error("outputs busy after reset");
  // wake and reset requests, and interrupt drop
  chk_wake_stop: assert property (wakeReq |-> stopMode)
    else $error("wake outside stop");
  chk_wake_hold: assert property (wakeHeld |-> wakeReq)
    else $error("wake dropped");
  chk_rst_pulse: assert property (cpuResetReq |=> !cpuResetReq)
    else $error("reset request too long");
  chk_rst_cause: assert property (cpuResetReq |-> $past(intervalOverflow) ||
    $past(intervalOverflow, 2) || $past(intervalOverflow, 3) || $past(intervalOverflow, 4))
    else $error("reset request without step");
  chk_irq_drop: assert property ($fell(irq) |-> $past(ack_o) || $past(ack_o, 2))
    else $error("irq fell without access");
endmodule
bind watch_timer_with_watchdog watch_timer_monitor mon_u (.core_clk(core_clk),
  .sys_rst(sys_rst), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .stopMode(stopMode),
  .intervalOverflow(intervalOverflow), .irq(irq), .wakeReq(wakeReq),
  .cpuResetReq(cpuResetReq));

// [tb/watch_timer_with_watchdog_test.sv]
`timescale 1ns/1ps
module watch_timer_with_watchdog_test
  import watch_timer_pkg::*;
();
  // design stimulus and results
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [9:0] adr_i = 10'h000;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h00000000;
  logic subClkPin = 1'b0, stopMode = 1'b0, intervalOverflow = 1'b0;
  logic [31:0] dat_o;
  logic ack_o, irq, wakeReq, cpuResetReq;
  // bench state and scenario tables
  int numErrors = 0, checkCount = 0, cyc = 0, ackAt = 0, resetSeen = 0;
  int t0, t1, base, n;
  logic [31:0] rd;
  logic [20:0] v0;
  logic [7:0] r;
  int src[7] = '{2, 3, 1, 0, 1, 0, 2};
  int en[7] = '{1, 1, 1, 1, 1, 1, 0};
  int stp[7] = '{0, 0, 0, 0, 1, 1, 0};
  int dv[7] = '{1, 2, 128, 16, 0, 16, 0};
  logic [7:0] ri[9] = '{IDX_WATCH_MODE_CONTROL, IDX_WATCHDOG_COMPARE, IDX_IRQ_MASK,
    IDX_IRQ_STATUS, IDX_WATCH_INTERVAL_RELOAD, IDX_WATCHDOG_CONTROL, IDX_WATCH_COUNT,
    IDX_WATCHDOG_COUNT, 8'h10};
  logic [7:0] rv[9] = '{RST_WATCH_MODE_CONTROL, RST_WATCHDOG_COMPARE, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  watch_timer_with_watchdog dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .subClkPin(subClkPin), .stopMode(stopMode),
    .intervalOverflow(intervalOverflow), .irq(irq), .wakeReq(wakeReq),
    .cpuResetReq(cpuResetReq));

  // core clock
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  // cycle stamp, sub-clock at a sixteenth of core rate, reset pulse count
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    subClkPin <= cyc[3];
    resetSeen <= resetSeen + (cpuResetReq === 1'b1);
  end

  // cycles from a clear write's ack to irq seen, beyond one period: clear, event, status flops
  localparam int IRQ_LATENCY = 3;

  // expected tick count and interrupt period
  function int rateExp(int d, int div);
    return div == 0 ? 0 : d / div;
  endfunction
  function int periodOf(int i);
    return i == 0 ? 1 << 11 : i == 1 ? 1 << 13 : i == 2 ? 1 << 14 : 2 << 14;
  endfunction

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      numErrors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // one classic cycle, then two idle cycles
  task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int k;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= 4'hf;
    dat_i <= {24'h000000, d};
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    if (k >= 20) begin
      numErrors++;
      report_and_stop;
    end
    rd = dat_o;
    ackAt = cyc;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  task waitIrq(output int at);
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 40000) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 40000) begin
      numErrors++;
      report_and_stop;
    end
    at = cyc;
  endtask

  task step(input logic [7:0] k);
    repeat (k) begin
      intervalOverflow <= 1'b1;
      @(posedge core_clk);
      intervalOverflow <= 1'b0;
      @(posedge core_clk);
    end
  endtask

  // main sequence
  initial begin
    void'($urandom(32'hf91cec75));
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < 9; i++) begin
      bus(1'b0, ri[i], 8'h00);
      check("reset value", {24'h000000, rv[i]}, rd);
    end
    r = 8'($urandom);
    bus(1'b1, IDX_WATCH_MODE_CONTROL, r);
    bus(1'b0, IDX_WATCH_MODE_CONTROL, 8'h00);
    check("mode control", {24'h000000, r & MODE_CONTROL_USED_MASK}, rd);
    $display("test registers done");
    bus(1'b1, IDX_WATCH_MODE_CONTROL, 8'h40);
    bus(1'b1, IDX_WATCHDOG_COMPARE, 8'h15);
    bus(1'b0, IDX_WATCHDOG_COMPARE, 8'h00);
    check("compare blocked", 32'h0000007f, rd);
    r = 8'h03 + 8'($urandom_range(7));
    bus(1'b1, IDX_WATCH_MODE_CONTROL, 8'h00);
    bus(1'b1, IDX_WATCHDOG_COMPARE, r);
    bus(1'b0, IDX_WATCHDOG_COMPARE, 8'h00);
    check("compare open", {24'h000000, r}, rd);
    $display("test write select done");
    bus(1'b1, IDX_WATCHDOG_CONTROL, 8'h01);
    step(r - 8'h01);
    bus(1'b0, IDX_WATCHDOG_COUNT, 8'h00);
    check("watchdog count", {24'h000000, r - 8'h01}, rd);
    bus(1'b1, IDX_WATCHDOG_CONTROL, 8'h01);
    bus(1'b0, IDX_WATCHDOG_CONTROL, 8'h00);
    check("clear bit", 32'h00000000, rd);
    bus(1'b0, IDX_WATCHDOG_COUNT, 8'h00);
    check("watchdog cleared", 32'h00000000, rd);
    step(r);
    check("masked irq", 32'h00000000, {31'h0, irq});
    bus(1'b1, IDX_IRQ_MASK, 8'h02);
    check("unmasked irq", 32'h00000001, {31'h0, irq});
    bus(1'b0, IDX_IRQ_STATUS, 8'h00);
    check("watchdog status", 32'h00000002, rd);
    check("irq after read", 32'h00000000, {31'h0, irq});
    bus(1'b1, IDX_WATCHDOG_CONTROL, 8'h03);
    n = resetSeen;
    step(r);
    repeat (4) @(posedge core_clk);
    check("reset pulses", 32'd1, resetSeen - n);
    bus(1'b0, IDX_IRQ_STATUS, 8'h00);
    check("no watchdog irq", 32'h00000000, rd);
    $display("test watchdog done");
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, IDX_WATCH_MODE_CONTROL, {en[i][0], 5'b10011, src[i][1:0]});
      bus(1'b1, IDX_WATCH_INTERVAL_RELOAD, 8'hff);
      stopMode <= stp[i][0];
      bus(1'b0, IDX_WATCH_COUNT, 8'h00);
      v0 = rd[20:0];
      t0 = ackAt;
      repeat (252) @(posedge core_clk);
      bus(1'b0, IDX_WATCH_COUNT, 8'h00);
      n = rateExp(ackAt - t0, dv[i]);
      check("watch ticks", n, {11'h0, rd[20:0] - v0});
    end
    stopMode <= 1'b0;
    $display("test watch sources done");
    bus(1'b1, IDX_IRQ_MASK, 8'h01);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, IDX_WATCH_MODE_CONTROL, {4'hc, i[1:0], 2'b10});
      bus(1'b1, IDX_WATCH_INTERVAL_RELOAD, {1'b1, 6'h00, i == 3});
      t0 = ackAt;
      bus(1'b0, IDX_IRQ_STATUS, 8'h00);
      waitIrq(t1);
      if (i == 0) begin
        base = t1 - t0 - periodOf(0);
        check("irq latency", IRQ_LATENCY, base);
        bus(1'b0, IDX_IRQ_STATUS, 8'h00);
        t0 = t1;
        waitIrq(t1);
        check("irq spacing", periodOf(0), t1 - t0);
      end else begin
        check("irq period", periodOf(i), t1 - t0 - base);
      end
    end
    stopMode <= 1'b1;
    repeat (2) @(posedge core_clk);
    check("wake", 32'h00000001, {31'h0, wakeReq});
    stopMode <= 1'b0;
    $display("test watch interrupts done");
    report_and_stop;
  end
endmodule
